// ===== hw/amem_pkg.sv
// Package for the asynchronous memory interface: register map, fields, states and carrier types
package amem_pkg;

  localparam int NUM_REGIONS = 4;
  localparam int ADDR_W = 23;

  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] OFS_CFG_BASE = 8'h10;
  localparam logic [7:0] OFS_WAIT_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Fields of async_region_config
  localparam int CFG_SS_BIT = 31;
  localparam int CFG_EW_BIT = 30;
  localparam int CFG_WSU_LSB = 26;
  localparam int CFG_WSTB_LSB = 20;
  localparam int CFG_WHLD_LSB = 17;
  localparam int CFG_RSU_LSB = 13;
  localparam int CFG_RSTB_LSB = 7;
  localparam int CFG_RHLD_LSB = 4;
  localparam int CFG_NAND_BIT = 2;
  localparam int CFG_BUS_WIDTH_FIELD_LSB = 0;
  localparam logic [31:0] CFG_RESET = 32'h3FFF_FFFC;

  // Fields of wait_cycle_config
  localparam int WAIT_POL_BIT = 28;
  localparam int WAIT_MAX_LSB = 0;
  localparam logic [31:0] WAIT_CFG_RESET = 32'h1000_0080;

  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam int ECC_MAX_BYTES = 518;

  typedef struct packed {
    logic ss;
    logic ew;
    logic [3:0] wSetup;
    logic [5:0] wStrobe;
    logic [2:0] wHold;
    logic [3:0] rSetup;
    logic [5:0] rStrobe;
    logic [2:0] rHold;
    logic nandMode;
    logic [1:0] busWidth;
  } region_cfg_t;

  // Request from an internal requester
  typedef struct packed {
    logic write;
    logic [1:0] region;
    logic [24:0] wordAddr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } mem_req_t;

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_t;

  function automatic region_cfg_t unpack_cfg(input logic [31:0] r);
    region_cfg_t c;
    c.ss = r[CFG_SS_BIT];
    c.ew = r[CFG_EW_BIT];
    c.wSetup = r[CFG_WSU_LSB +: 4];
    c.wStrobe = r[CFG_WSTB_LSB +: 6];
    c.wHold = r[CFG_WHLD_LSB +: 3];
    c.rSetup = r[CFG_RSU_LSB +: 4];
    c.rStrobe = r[CFG_RSTB_LSB +: 6];
    c.rHold = r[CFG_RHLD_LSB +: 3];
    c.nandMode = r[CFG_NAND_BIT];
    c.busWidth = r[CFG_BUS_WIDTH_FIELD_LSB +: 2];
    return c;
  endfunction : unpack_cfg

endpackage : amem_pkg

// ===== hw/amem_sync2.sv
// Two-flop synchroniser for a pin input
`timescale 1ns/1ns
module amem_sync2 (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pinIn,
  output logic pinSync
);
  logic meta_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      meta_q <= pinIn;
      pinSync <= meta_q;
    end
  end
endmodule : amem_sync2

// ===== hw/amem_ecc.sv
// Column parity accumulator for the NAND sub-mode, one byte lane per step
`timescale 1ns/1ns
module amem_ecc (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic byteValid,
  input wire logic [7:0] dataByte,
  output logic [31:0] eccValue
);
  logic [9:0] count_q;
  logic [7:0] colPar_q;
  logic [9:0] linePar_q;
  logic bytePar;

  assign bytePar = ^dataByte;
  assign eccValue = {4'h0, count_q, linePar_q, colPar_q};

  // Accumulates only up to the largest block the code covers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 10'h000;
      colPar_q <= 8'h00;
      linePar_q <= 10'h000;
    end else if (clear) begin
      count_q <= 10'h000;
      colPar_q <= 8'h00;
      linePar_q <= 10'h000;
    end else if (byteValid && count_q < 10'(amem_pkg::ECC_MAX_BYTES)) begin
      count_q <= count_q + 10'h001;
      colPar_q <= colPar_q ^ dataByte;
      linePar_q <= linePar_q ^ (bytePar ? count_q : 10'h000);
    end
  end
endmodule : amem_ecc

// ===== hw/async_memory_interface.sv
// Asynchronous memory interface: register port, region timing engine and pin drivers
`timescale 1ns/1ns
module async_memory_interface
  import amem_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic reqValid,
  input wire mem_req_t req,
  output logic reqReady,
  output logic rspValid,
  output logic [31:0] rspData,
  output logic [ADDR_W-1:0] address_out,
  output logic [1:0] low_address_out,
  output logic [NUM_REGIONS-1:0] region_select_out_b,
  output logic [1:0] byte_enable_out_b,
  output logic read_strobe_out_b,
  output logic write_strobe_out_b,
  input wire logic [15:0] data_pins_in,
  output logic [15:0] data_pins_out,
  output logic data_pins_oe,
  input wire logic wait_input
);

  logic [31:0] cfg_q [NUM_REGIONS];
  logic [31:0] waitCfg_q;
  phase_t phase_q;
  mem_req_t cur_q;
  region_cfg_t act_q;
  logic [5:0] cnt_q;
  logic [1:0] step_q;
  logic [31:0] rdAcc_q;
  logic [9:0] waitCnt_q;
  logic timeout_q;
  logic eccClr_q;
  logic waitSync;
  logic waitActive;
  logic lastStep;
  logic [1:0] lane;
  logic [31:0] eccValue;
  logic eccStrobe;
  logic [24:0] nextAddr;
  logic [1:0] stepsM1;
  region_cfg_t reqCfg;

  amem_sync2 u_wait_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pinIn(wait_input),
    .pinSync(waitSync)
  );

  // Wait is active when extended wait is enabled and the synchronised pin matches the polarity bit
  assign waitActive = act_q.ew && (waitSync == waitCfg_q[WAIT_POL_BIT]);
  assign stepsM1 = (act_q.busWidth == WIDTH_8) ? 2'h3 : 2'h1;
  assign lastStep = (step_q == stepsM1);
  assign lane = (act_q.busWidth == WIDTH_8) ? step_q : {step_q[0], 1'b0};
  assign reqCfg = unpack_cfg(cfg_q[req.region]);

  // Register port
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
      waitCfg_q <= WAIT_CFG_RESET;
      eccClr_q <= 1'b0;
    end else begin
      eccClr_q <= 1'b0;
      if (regWrite) begin
        for (int i = 0; i < NUM_REGIONS; i++) begin
          if (regAddr == OFS_CFG_BASE + 8'(4 * i)) begin
            cfg_q[i] <= regWdata;
          end
        end
        if (regAddr == OFS_WAIT_CFG) begin
          waitCfg_q <= regWdata;
        end
        if (regAddr == OFS_STATUS) begin
          eccClr_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= 32'h0000_0000;
      if (regRead) begin
        for (int i = 0; i < NUM_REGIONS; i++) begin
          if (regAddr == OFS_CFG_BASE + 8'(4 * i)) begin
            regRdata <= cfg_q[i];
          end
        end
        if (regAddr == OFS_WAIT_CFG) begin
          regRdata <= waitCfg_q;
        end
        if (regAddr == OFS_STATUS) begin
          regRdata <= {timeout_q, phase_q != PH_IDLE, eccValue[29:0]};
        end
      end
    end
  end

  // Access sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= PH_IDLE;
      cur_q <= '0;
      act_q <= '0;
      cnt_q <= 6'h00;
      step_q <= 2'h0;
      rdAcc_q <= 32'h0000_0000;
      waitCnt_q <= 10'h000;
      timeout_q <= 1'b0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 32'h0000_0000;
    end else begin
      rspValid <= 1'b0;
      reqReady <= 1'b0;
      // Clear first so a timeout in the same cycle still sets the flag
      if (regWrite && regAddr == OFS_STATUS && regWdata[31]) begin
        timeout_q <= 1'b0;
      end
      unique case (phase_q)
        PH_IDLE: begin
          if (reqValid && !reqReady) begin
            cur_q <= req;
            act_q <= reqCfg;
            step_q <= 2'h0;
            cnt_q <= req.write ? 6'(reqCfg.wSetup) : 6'(reqCfg.rSetup);
            reqReady <= 1'b1;
            phase_q <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt_q == 6'h00) begin
            cnt_q <= cur_q.write ? act_q.wStrobe : act_q.rStrobe;
            waitCnt_q <= 10'h000;
            phase_q <= PH_STROBE;
          end else begin
            cnt_q <= cnt_q - 6'h01;
          end
        end
        PH_STROBE: begin
          if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
          end else if (waitActive && waitCnt_q != {waitCfg_q[WAIT_MAX_LSB +: 6], 4'hF}) begin
            waitCnt_q <= waitCnt_q + 10'h001;
          end else begin
            if (waitActive) begin
              timeout_q <= 1'b1;
            end
            if (act_q.busWidth == WIDTH_8) begin
              rdAcc_q[8*lane +: 8] <= data_pins_in[7:0];
            end else begin
              rdAcc_q[8*lane +: 16] <= data_pins_in;
            end
            cnt_q <= cur_q.write ? 6'(act_q.wHold) : 6'(act_q.rHold);
            phase_q <= PH_HOLD;
          end
        end
        PH_HOLD: begin
          if (cnt_q != 6'h00) begin
            cnt_q <= cnt_q - 6'h01;
          end else if (lastStep) begin
            rspValid <= !cur_q.write;
            rspData <= rdAcc_q;
            phase_q <= PH_IDLE;
          end else begin
            step_q <= step_q + 2'h1;
            cnt_q <= cur_q.write ? 6'(act_q.wSetup) : 6'(act_q.rSetup);
            phase_q <= PH_SETUP;
          end
        end
      endcase
    end
  end

  assign nextAddr = cur_q.wordAddr;

  // Pin drivers, all registered from the current phase view
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      address_out <= '0;
      low_address_out <= 2'h0;
      region_select_out_b <= '1;
      byte_enable_out_b <= 2'h3;
      read_strobe_out_b <= 1'b1;
      write_strobe_out_b <= 1'b1;
      data_pins_out <= 16'h0000;
      data_pins_oe <= 1'b0;
    end else begin
      region_select_out_b <= '1;
      read_strobe_out_b <= 1'b1;
      write_strobe_out_b <= 1'b1;
      data_pins_oe <= 1'b0;
      if (phase_q != PH_IDLE) begin
        address_out <= nextAddr[ADDR_W-1:0];
        if (act_q.busWidth == WIDTH_8) begin
          low_address_out <= lane;
          byte_enable_out_b <= {1'b1, ~cur_q.byteEn[lane]};
          data_pins_out <= {8'h00, cur_q.wdata[8*lane +: 8]};
        end else begin
          low_address_out <= {step_q[0], nextAddr[ADDR_W-1]};
          byte_enable_out_b <= ~cur_q.byteEn[lane +: 2];
          data_pins_out <= cur_q.wdata[8*lane +: 16];
        end
        data_pins_oe <= cur_q.write;
        if (!act_q.ss || phase_q == PH_STROBE) begin
          region_select_out_b[cur_q.region] <= 1'b0;
        end
        if (phase_q == PH_STROBE) begin
          read_strobe_out_b <= cur_q.write;
          write_strobe_out_b <= !cur_q.write;
        end
      end
    end
  end

  // NAND sub-mode parity on the low read byte lane of each step as it is captured without wait
  assign eccStrobe = act_q.nandMode && !cur_q.write && phase_q == PH_STROBE && cnt_q == 6'h00 && !waitActive;

  amem_ecc u_ecc (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clear(eccClr_q),
    .byteValid(eccStrobe),
    .dataByte(data_pins_in[7:0]),
    .eccValue(eccValue)
  );

  strobe_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (act_q.ss && phase_q == PH_SETUP) |=> region_select_out_b == '1)
    else $error("select active outside strobe in strobe mode");
  normal_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!act_q.ss && phase_q == PH_HOLD) |=> region_select_out_b[cur_q.region] == 1'b0)
    else $error("select dropped in hold in normal mode");
  no_overlap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(read_strobe_out_b == 1'b0 && write_strobe_out_b == 1'b0))
    else $error("both strobes low");
  wait_stretch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_q == PH_STROBE && cnt_q == 6'h00 && waitActive && waitCnt_q == 10'h000) |=> phase_q == PH_STROBE)
    else $error("wait did not stretch strobe");
  write_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_q == PH_SETUP && cur_q.write) |=> data_pins_oe)
    else $error("write data not driven in setup");
  setup_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_q == PH_IDLE && $past(phase_q) == PH_IDLE && reqValid && !reqReady && !req.write
     && reqCfg.rSetup == 4'h1) |=> phase_q == PH_SETUP ##1 phase_q == PH_SETUP ##1 phase_q == PH_STROBE)
    else $error("read setup length wrong");
  reset_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> !cfg_q[0][CFG_SS_BIT])
    else $error("region not in normal mode after reset");
  hold_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_q == PH_HOLD && cnt_q != 6'h00) |=> $stable(address_out))
    else $error("address moved during hold");
  lane_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_q != PH_IDLE && act_q.busWidth == WIDTH_8) |=> byte_enable_out_b[1])
    else $error("upper byte enable active on 8-bit bus");
  upper_line_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_q != PH_IDLE && act_q.busWidth != WIDTH_8) |=> low_address_out[0] == cur_q.wordAddr[ADDR_W-1])
    else $error("low address pin 0 not upper line on 16-bit bus");
  idle_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_q == PH_IDLE) |=> (region_select_out_b == '1 && read_strobe_out_b && write_strobe_out_b))
    else $error("pins active while idle");

  read_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_b) rspValid);
  write_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_b) !write_strobe_out_b);
  wait_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_b) waitCnt_q == 10'h002);
  ss_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_b) act_q.ss && !write_strobe_out_b);
  ecc_cov_c: cover property (@(posedge ref_clk) disable iff (!rst_b) eccStrobe);

endmodule : async_memory_interface

// ===== bench/amem_mem_model.sv
// Behavioural asynchronous memory with a pin pattern for reads and a wait pulse
`timescale 1ns/1ns
module amem_mem_model (
  input wire logic ref_clk,
  input wire logic selB,
  input wire logic oeB,
  input wire logic strbB,
  input wire logic [1:0] lowAddr,
  input wire logic waitPol,
  input wire logic [3:0] waitLen,
  output logic [15:0] dOut,
  output logic waitPin
);
  logic [15:0] lastQ = 16'h0;
  logic [3:0] cntQ = 4'h0;
  logic strbQ = 1'h1;
  logic drv;
  assign drv = !selB && !oeB;
  // Released bus shows the inverse of the last value, never a stale copy
  assign dOut = drv ? {6'h2C, lowAddr, 6'h28, lowAddr} : ~lastQ;
  // Wait rises with the strobe's fall so the two-flop path sees it before the strobe count ends
  assign waitPin = (cntQ != 4'h0 || (waitLen != 4'h0 && strbQ && !strbB)) ? waitPol : !waitPol;
  always @(posedge ref_clk) begin
    strbQ <= strbB;
    if (drv) lastQ <= dOut;
    if (strbQ && !strbB) cntQ <= waitLen;
    else if (cntQ != 4'h0) cntQ <= cntQ - 4'h1;
  end
endmodule : amem_mem_model

// ===== bench/tb_top.sv
// Self-checking bench for the asynchronous memory interface
`timescale 1ns/1ns
module tb_top;
  import amem_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic [31:0] regRdata;
  logic reqValid = 1'h0;
  mem_req_t req = '0;
  logic reqReady, rspValid, rdB, wrB, oe, wp, waitPol = 1'h1;
  logic [31:0] rspData;
  logic [ADDR_W-1:0] ao, capA;
  logic [1:0] la, be;
  logic [3:0] selB, waitLen = 4'h0;
  logic [15:0] dIn, dOut;
  logic [1:0] capL [4];
  logic [1:0] capB [4];
  logic [15:0] capD [4];
  logic [1:0] capO;
  int err_count = 0, total_checks = 0, cyc = 0;
  int sc, sh, sl, so, si, rg;
  logic strb, strbP = 1'h1;
  always #5 ref_clk = ~ref_clk;
  async_memory_interface u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .address_out(ao), .low_address_out(la),
    .region_select_out_b(selB), .byte_enable_out_b(be), .read_strobe_out_b(rdB), .write_strobe_out_b(wrB),
    .data_pins_in(dIn), .data_pins_out(dOut), .data_pins_oe(oe), .wait_input(wp));
  amem_mem_model u_mem (.ref_clk(ref_clk), .selB(&selB), .oeB(rdB), .strbB(strb), .lowAddr(la),
    .waitPol(waitPol), .waitLen(waitLen), .dOut(dIn), .waitPin(wp));
  assign strb = rdB & wrB;
  always @(posedge ref_clk) begin
    strbP <= strb;
    if (!selB[rg]) begin
      if (strb) sh++;
      else sl++;
    end
    if ((~selB & ~(4'h1 << rg)) != 4'h0) so++;
    if (!strb) sc++;
    if (!strb && strbP) begin
      capL[si[1:0]] = la;
      capB[si[1:0]] = be;
      capD[si[1:0]] = dOut;
      capO[si[0]] = oe;
      capA = ao;
      si++;
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge ref_clk);
    regWrite <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge ref_clk);
    regRead <= 1'h0;
    #1 d = regRdata;
  endtask : rd
  function automatic logic [31:0] mk(input logic ss, ew, input logic [3:0] ws, input logic [5:0] wt,
    input logic [2:0] wh, input logic [3:0] rs, input logic [5:0] rt, input logic [2:0] rh, input logic [1:0] w);
    return {ss, ew, ws, wt, wh, rs, rt, rh, 2'h0, w}; // Flash sub-mode never joined with extended wait
  endfunction : mk
  task automatic doReq(input logic w, input logic [24:0] a, output logic [31:0] d);
    int n;
    logic [31:0] st;
    sc = 0;
    sh = 0;
    sl = 0;
    so = 0;
    si = 0;
    n = 0;
    @(posedge ref_clk);
    reqValid <= 1'h1;
    req <= {w, 2'(rg), a, 4'h6, 32'hCAFE1234};
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (reqReady !== 1'h1 && n < 50);
    @(posedge ref_clk);
    reqValid <= 1'h0;
    d = 32'h0;
    st = 32'hFFFFFFFF;
    while (!w && rspValid !== 1'h1 && n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (!w) begin
      d = rspData;
      @(posedge ref_clk);
      #1 n++;
    end
    while (w && st[30] !== 1'h0 && n < 200) begin
      rd(OFS_STATUS, st);
      n++;
    end
    chk("ordone", 32'h1, n < 190);
    chk("others", 32'h0, so);
  endtask : doReq
  task automatic tRegs();
    logic [31:0] v;
    rd(OFS_CFG_BASE, v);
    chk("cfgrst", CFG_RESET, v);
    rd(OFS_WAIT_CFG, v);
    chk("waitrst", WAIT_CFG_RESET, v);
    wr(8'hF0, 32'hFFFFFFFF);
    rd(8'hF0, v);
    chk("unmap", 32'h0, v);
  endtask : tRegs
  task automatic tTiming();
    logic [31:0] d;
    for (int r = 0; r < 4; r++) begin
      rg = r;
      wr(OFS_CFG_BASE + 8'(4 * r), mk(1'h0, 1'h0, 4'(r + 1), 6'h2, 3'(r), 4'h3, 6'h1, 3'h0, WIDTH_16));
      doReq(1'h1, 25'h10, d);
      chk("wstrb", 6, sc);
      chk("wsel", 2 * (2 * r + 3), sh);
      chk("wsellow", sc, sl);
      chk("wbe", 32'h9, {capB[1], capB[0]});
      chk("wdata", 32'hCAFE1234, {capD[1], capD[0]});
      chk("woe", 32'h3, capO);
      doReq(1'h0, 25'h0400005, d);
      chk("rstrb", 4, sc);
      chk("rsel", 10, sh);
      chk("rdata", 32'hB3A3B1A1, d);
      chk("rlow", 32'hD, {capL[1], capL[0]});
      chk("raddr", 32'h400005, capA);
    end
  endtask : tTiming
  task automatic tStrobe();
    logic [31:0] d;
    rg = 1;
    wr(OFS_CFG_BASE + 8'h4, mk(1'h1, 1'h0, 4'h2, 6'h3, 3'h1, 4'h0, 6'h1, 3'h0, WIDTH_16));
    doReq(1'h1, 25'h20, d);
    chk("sssetup", 0, sh);
    chk("ssstrb", 8, sl);
    chk("ssbe", 32'h9, {capB[1], capB[0]});
  endtask : tStrobe
  task automatic tByte();
    logic [31:0] d;
    logic [31:0] v;
    rg = 2;
    wr(OFS_CFG_BASE + 8'h8, mk(1'h0, 1'h0, 4'h0, 6'h1, 3'h0, 4'h1, 6'h2, 3'h1, WIDTH_8) | (32'h1 << CFG_NAND_BIT));
    wr(OFS_STATUS, 32'h0);
    doReq(1'h0, 25'h8, d);
    chk("bdata", 32'hA3A2A1A0, d);
    chk("bstrb", 12, sc);
    chk("blow", 32'hE4, {capL[3], capL[2], capL[1], capL[0]});
    rd(OFS_STATUS, v);
    chk("ecccnt", 32'h4, 32'(v[27:18]));
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS, v);
    chk("eccclr", 32'h0, v);
  endtask : tByte
  task automatic tWait();
    logic [31:0] d;
    rg = 3;
    wr(OFS_CFG_BASE + 8'hC, mk(1'h0, 1'h1, 4'h0, 6'h1, 3'h0, 4'h0, 6'h4, 3'h0, WIDTH_16));
    for (int p = 1; p >= 0; p--) begin
      waitPol <= 1'(p);
      wr(OFS_WAIT_CFG, {WAIT_CFG_RESET[31:29], 1'(p), WAIT_CFG_RESET[27:0]});
      waitLen <= 4'h6;
      doReq(1'h0, 25'h30, d);
      chk("wext", 32'h1, sc > 10);
    end
    wr(OFS_CFG_BASE + 8'hC, mk(1'h0, 1'h0, 4'h0, 6'h1, 3'h0, 4'h0, 6'h4, 3'h0, WIDTH_16));
    doReq(1'h0, 25'h30, d);
    chk("wignore", 10, sc);
    waitLen <= 4'h0;
  endtask : tWait
  initial begin
    rg = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    tRegs();
    tTiming();
    tStrobe();
    tByte();
    tWait();
    wrap_up();
  end
endmodule : tb_top
